/* iaspi_host_model.sv */
// Behavioural SPI master that faces the serial slave
`timescale 1ns/1ns
`default_nettype none
module iaspi_host_model (
   input wire logic clk,
   input wire logic miso,
   output var iaspi_pkg::iaspi_pins_t pins
);
   import iaspi_pkg::*;
   initial pins = '{sclk: 1'b1, cs_n: 1'b1, mosi: 1'b0};
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Sends nbits from the top of tx; the last 8 bits seen on MISO land in rx
   task automatic xfer(input logic [15:0] tx, input int nbits, output logic [7:0] rx);
      rx = 8'h00;
      pins.cs_n = 1'b0;
      tick(4);
      for (int i = 15; i > 15 - nbits; i--) begin
         pins.sclk = 1'b0;
         pins.mosi = tx[i];
         tick(4);
         rx = {rx[6:0], miso};
         pins.sclk = 1'b1;
         tick(4);
      end
      pins.cs_n = 1'b1;
      // Released line shows the opposite level, not the last bit
      pins.mosi = ~pins.mosi;
      tick(8);
   endtask
endmodule // iaspi_host_model
`default_nettype wire

/* iaspi_pkg.sv */
// Shared constants and types for the isolated converter serial slave
package iaspi_pkg;
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned IDX_W = 5;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned REG_NUM = 32;
   localparam int unsigned BITCNT_W = 3;
   localparam logic [BITCNT_W-1:0] LAST_BIT = 3'h7;
   localparam logic [BITCNT_W-1:0] FIRST_BIT = 3'h0;
   // Data-ready strobe length in input-clock cycles
   localparam int unsigned DRDY_CYCLES = 64;
   localparam int unsigned DRDY_W = 7;
   localparam logic [DRDY_W-1:0] DRDY_LOAD = 7'h40;
   localparam logic [DRDY_W-1:0] DRDY_ZERO = 7'h00;
   // Register indices (five-bit index field of the command byte)
   localparam logic [IDX_W-1:0] SETUP_IDX = 5'h08;
   localparam logic [IDX_W-1:0] STATUS_IDX = 5'h09;
   // Field positions
   localparam int unsigned CLK_FWD_BIT = 0;
   localparam int unsigned RST_PEND_BIT = 0;
   localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
   localparam int unsigned RST_CNT_W = 16;

   typedef struct packed {
      logic sclk;
      logic cs_n;
      logic mosi;
   } iaspi_pins_t;

   typedef struct packed {
      logic [IDX_W-1:0] index;
      logic read_sel;
      logic [1:0] ignored;
   } iaspi_cmd_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_CMD = 3'b001,
      ST_RDATA = 3'b011,
      ST_WDATA = 3'b010,
      ST_DONE = 3'b110
   } iaspi_state_t;
endpackage

/* iaspi_slave.sv */
// Serial slave port, register store, data-ready strobe and clock forward
`timescale 1ns/1ns
`default_nettype none
// How it works
// [R1] Capture MOSI on rising serial clock
// [R2] Shift MISO out on falling serial clock
// [R3] Most significant bit first both ways
// [R4] Master keeps serial clock 250 kHz-5.6 MHz
// [R5] MISO high-impedance unless sending data bits
// [R6] Master holds select low whole transfer
// [R7] Select high mid-transfer aborts, no write
// [R8] Select falling edge starts new command byte
// [R9] Strobe low exactly 64 input clocks
// [R10] Input clock 3.6 to 4.21 MHz; CLK_HZ and the bench clock are 20 MHz
// [R11] Reset-pending status bit clears after reset
// [R12] Command: index 7:3, read bit 2
// [R13] Read data starts at next falling edge
// [R14] Write is command plus one data byte
// [R15] Pin forwards clock when setup bit set
// [R16] Commit write only after eight bits
// [R17] Serial pins synchronized into clock domain
module iaspi_slave #(
   parameter int unsigned RST_DONE_CYCLES = 64
) (
   input wire logic clk,
   input wire logic rstn,
   input wire iaspi_pkg::iaspi_pins_t pins,
   input wire logic result_ready,
   output logic miso_o,
   output logic miso_oe_n,
   output logic ready_clk_pin,
   output logic wr_valid,
   output logic [iaspi_pkg::IDX_W-1:0] wr_index,
   output logic [iaspi_pkg::DATA_W-1:0] wr_data,
   output logic clock_forward_select,
   output logic reset_pending
);
   import iaspi_pkg::*;

   iaspi_pins_t lvl;
   logic sclk_rise, sclk_fall, cs_fall, cs_rise;
   iaspi_state_t state_q;
   logic [BITCNT_W-1:0] bit_cnt_q;
   logic [DATA_W-1:0] in_sh_q;
   logic [DATA_W-1:0] out_sh_q;
   iaspi_cmd_t cmd_q;
   logic [DATA_W-1:0] regs_q [REG_NUM];
   logic miso_q, miso_oe_n_q;
   logic wr_valid_q;
   logic [IDX_W-1:0] wr_index_q;
   logic [DATA_W-1:0] wr_data_q;
   logic rst_pend_q;
   logic [RST_CNT_W-1:0] rst_cnt_q;
   logic [DRDY_W-1:0] drdy_cnt_q, drdy_cnt_d;
   logic pin_q;
   logic [DATA_W-1:0] byte_in;
   iaspi_cmd_t cmd_in;

   iaspi_sync u_sync (
      .clk(clk),
      .rstn(rstn),
      .pins(pins),
      .level(lvl),
      .sclk_rise(sclk_rise),
      .sclk_fall(sclk_fall),
      .cs_fall(cs_fall),
      .cs_rise(cs_rise)
   );

   // Read value of an index; status is built from live state
   function automatic logic [DATA_W-1:0] read_value(input logic [IDX_W-1:0] idx,
                                                     input logic pend);
      logic [DATA_W-1:0] v;
      v = regs_q[idx];
      if (idx == STATUS_IDX) begin
         v = '0;
         v[RST_PEND_BIT] = pend; // R11
      end
      return v;
   endfunction

   assign byte_in = {in_sh_q[DATA_W-2:0], lvl.mosi}; // R1 R3
   assign cmd_in = iaspi_cmd_t'(byte_in); // R12

   // Transfer sequencing
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_q <= ST_IDLE;
         bit_cnt_q <= FIRST_BIT;
         in_sh_q <= '0;
         cmd_q <= '0;
      end else if (lvl.cs_n) begin
         state_q <= ST_IDLE; // R7
         bit_cnt_q <= FIRST_BIT;
      end else if (cs_fall) begin
         state_q <= ST_CMD; // R8
         bit_cnt_q <= FIRST_BIT;
      end else if (sclk_rise) begin
         in_sh_q <= byte_in; // R1
         bit_cnt_q <= bit_cnt_q + 3'h1;
         case (state_q)
            ST_CMD: begin
               if (bit_cnt_q == LAST_BIT) begin
                  cmd_q <= cmd_in;
                  state_q <= cmd_in.read_sel ? ST_RDATA : ST_WDATA; // R12 R14
               end
            end
            ST_RDATA, ST_WDATA: begin
               if (bit_cnt_q == LAST_BIT) begin
                  state_q <= ST_DONE;
               end
            end
            ST_IDLE, ST_DONE: begin
               state_q <= state_q;
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // Outgoing shift register and MISO drive
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         out_sh_q <= '0;
         miso_q <= 1'b0;
         miso_oe_n_q <= 1'b1;
      end else if (lvl.cs_n || state_q != ST_RDATA) begin
         miso_oe_n_q <= 1'b1; // R5 R7
         if (state_q == ST_CMD && sclk_rise && bit_cnt_q == LAST_BIT) begin
            out_sh_q <= read_value(cmd_in.index, rst_pend_q);
         end
      end else if (sclk_fall) begin
         miso_q <= out_sh_q[DATA_W-1]; // R2 R3 R13
         miso_oe_n_q <= 1'b0;
         out_sh_q <= {out_sh_q[DATA_W-2:0], 1'b0};
      end
   end

   // Register store; commits only on a complete data byte
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < REG_NUM; i++) begin
            regs_q[i] <= REG_RESET;
         end
         wr_valid_q <= 1'b0;
         wr_index_q <= '0;
         wr_data_q <= '0;
      end else begin
         wr_valid_q <= 1'b0;
         if (!lvl.cs_n && !cs_fall && sclk_rise && state_q == ST_WDATA
             && bit_cnt_q == LAST_BIT) begin
            wr_valid_q <= 1'b1; // R16 R14
            wr_index_q <= cmd_q.index;
            wr_data_q <= byte_in;
            if (cmd_q.index != STATUS_IDX) begin
               regs_q[cmd_q.index] <= byte_in;
            end
         end
      end
   end

   // Reset-pending flag clears once the reset period is over
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rst_pend_q <= 1'b1;
         rst_cnt_q <= '0;
      end else if (rst_pend_q) begin
         rst_cnt_q <= rst_cnt_q + 16'h0001;
         if (rst_cnt_q == RST_CNT_W'(RST_DONE_CYCLES - 1)) begin
            rst_pend_q <= 1'b0; // R11
         end
      end
   end

   // Data-ready strobe counter; a new result restarts the pulse
   always_comb begin
      drdy_cnt_d = drdy_cnt_q;
      if (result_ready) begin
         drdy_cnt_d = DRDY_LOAD; // R9
      end else if (drdy_cnt_q != DRDY_ZERO) begin
         drdy_cnt_d = drdy_cnt_q - 7'h01;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         drdy_cnt_q <= DRDY_ZERO;
         pin_q <= 1'b1;
      end else begin
         drdy_cnt_q <= drdy_cnt_d;
         if (regs_q[SETUP_IDX][CLK_FWD_BIT]) begin
            pin_q <= ~pin_q; // R15
         end else begin
            pin_q <= (drdy_cnt_d == DRDY_ZERO); // R9
         end
      end
   end

   assign miso_o = miso_q;
   assign miso_oe_n = miso_oe_n_q;
   assign ready_clk_pin = pin_q;
   assign wr_valid = wr_valid_q;
   assign wr_index = wr_index_q;
   assign wr_data = wr_data_q;
   assign clock_forward_select = regs_q[SETUP_IDX][CLK_FWD_BIT];
   assign reset_pending = rst_pend_q;

   // Checks; a new result restarts the low count
   logic [DRDY_W:0] low_len_q;
   logic strobe_full_q;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         low_len_q <= '0;
      end else if (result_ready) begin
         low_len_q <= '0;
      end else if (!pin_q && !regs_q[SETUP_IDX][CLK_FWD_BIT]) begin
         low_len_q <= low_len_q + 8'h01;
      end else begin
         low_len_q <= '0;
      end
   end

   // Marks a strobe begun by a result in strobe mode, so a mode switch is not judged
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         strobe_full_q <= 1'b0;
      end else if (regs_q[SETUP_IDX][CLK_FWD_BIT]) begin
         strobe_full_q <= 1'b0;
      end else if (result_ready) begin
         strobe_full_q <= 1'b1;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   strobe_width_a: assert property ($rose(pin_q) && strobe_full_q // R9
      && !$past(regs_q[SETUP_IDX][CLK_FWD_BIT]) && !$past(result_ready)
      |-> low_len_q == (DRDY_W+1)'(DRDY_CYCLES))
      else $error("ready strobe not 64 cycles low");
   miso_idle_a: assert property (state_q != ST_RDATA |=> miso_oe_n_q) // R5
      else $error("MISO driven outside read data");
   abort_release_a: assert property (cs_rise |=> state_q == ST_IDLE && miso_oe_n_q) // R7
      else $error("select release did not abort");
   abort_nowrite_a: assert property (wr_valid_q |-> !$past(lvl.cs_n) // R16
      && $past(state_q) == ST_WDATA && $past(bit_cnt_q) == LAST_BIT)
      else $error("write committed without full byte");
   cmd_start_a: assert property (cs_fall |=> state_q == ST_CMD && bit_cnt_q == FIRST_BIT) // R8
      else $error("select fall did not start command");
   read_drive_a: assert property (state_q == ST_RDATA && !lvl.cs_n && sclk_fall // R2 R13
      |=> !miso_oe_n_q && miso_q == $past(out_sh_q[DATA_W-1]))
      else $error("read bit not driven on falling edge");
   msb_first_a: assert property (!lvl.cs_n && !cs_fall && sclk_rise // R1 R3
      |=> in_sh_q[0] == $past(lvl.mosi) && in_sh_q[DATA_W-1:1] == $past(in_sh_q[DATA_W-2:0]))
      else $error("MOSI shift order wrong");
   fwd_toggle_a: assert property (regs_q[SETUP_IDX][CLK_FWD_BIT] // R15
      |=> pin_q != $past(pin_q))
      else $error("forwarded clock not toggling");
   pend_stays_a: assert property (!rst_pend_q |=> !rst_pend_q) // R11
      else $error("reset pending flag set again");
   pend_clear_a: assert property ($fell(rst_pend_q) |-> $past(rst_cnt_q) // R11
      == RST_CNT_W'(RST_DONE_CYCLES - 1))
      else $error("reset pending cleared at wrong time");

   read_seen_c: cover property (state_q == ST_RDATA ##[1:400] state_q == ST_DONE);
   write_seen_c: cover property (wr_valid_q);
   abort_seen_c: cover property ((state_q == ST_WDATA || state_q == ST_RDATA) ##1 cs_rise);
   strobe_seen_c: cover property ($rose(pin_q) && low_len_q == (DRDY_W+1)'(DRDY_CYCLES));
endmodule // iaspi_slave
`default_nettype wire

/* iaspi_slave_tb_top.sv */
// Self-checking bench for the isolated converter serial slave
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin num_errors++; $display("unexpected %s exp %h got %h", nm, ex, got); end end
module iaspi_slave_tb_top;
   import iaspi_pkg::*;
   localparam int unsigned RST_CYC = 200;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic result_ready = 1'b0;
   iaspi_pins_t pins;
   logic miso, miso_o, miso_oe_n, ready_clk_pin, wr_valid, clock_forward_select, reset_pending;
   logic [IDX_W-1:0] wr_index;
   logic [DATA_W-1:0] wr_data;
   logic [7:0] rx;
   int num_errors = 0;
   int checked = 0;
   int wr_cnt = 0;
   int oe_cnt = 0;
   int cycles = 0;
   always #25 clk = ~clk;
   // Pull-up holds the released data line high
   assign miso = miso_oe_n ? 1'b1 : miso_o;
   iaspi_host_model host_u (.clk(clk), .miso(miso), .pins(pins));
   iaspi_slave #(.RST_DONE_CYCLES(RST_CYC)) dut_u (
      .clk(clk), .rstn(rstn), .pins(pins), .result_ready(result_ready),
      .miso_o(miso_o), .miso_oe_n(miso_oe_n), .ready_clk_pin(ready_clk_pin),
      .wr_valid(wr_valid), .wr_index(wr_index), .wr_data(wr_data),
      .clock_forward_select(clock_forward_select), .reset_pending(reset_pending)
   );
   task automatic conclude();
      if (num_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (wr_valid === 1'b1) wr_cnt++;
      if (miso_oe_n === 1'b0) oe_cnt++;
      if (cycles == 30000) begin
         num_errors++;
         conclude();
      end
   end
   task automatic wr(input logic [4:0] idx, input logic [7:0] d, input int n);
      host_u.xfer({idx, 1'b0, 2'b00, d}, n, rx);
   endtask
   // Don't-care bits set to ones on reads
   task automatic rd(input logic [4:0] idx, output logic [7:0] d);
      host_u.xfer({idx, 1'b1, 2'b11, 8'h00}, 16, d);
   endtask
   task automatic t_poll();
      logic [7:0] s;
      int n;
      n = 0;
      `CHK("pending", 1'b1, reset_pending)
      rd(STATUS_IDX, s);
      `CHK("status first", 1'b1, s[RST_PEND_BIT])
      while (s[RST_PEND_BIT] !== 1'b0 && n < 6) begin
         rd(STATUS_IDX, s);
         n++;
      end
      `CHK("status clear", 8'h00, s)
      `CHK("pending clear", 1'b0, reset_pending)
      wr(STATUS_IDX, 8'hff, 16);
      rd(STATUS_IDX, s);
      `CHK("status kept", 8'h00, s)
   endtask
   task automatic t_wr_rd();
      int w0, o0;
      w0 = wr_cnt;
      o0 = oe_cnt;
      wr(5'h03, 8'ha5, 16);
      `CHK("wr count", 1, wr_cnt - w0)
      `CHK("wr index", 5'h03, wr_index)
      `CHK("wr data", 8'ha5, wr_data)
      `CHK("oe on write", 0, oe_cnt - o0)
      rd(5'h03, rx);
      `CHK("readback", 8'ha5, rx)
      `CHK("oe on read", 1'b1, oe_cnt > o0)
      `CHK("oe idle", 1'b1, miso_oe_n)
   endtask
   task automatic t_abort();
      int w0;
      w0 = wr_cnt;
      wr(5'h03, 8'h3c, 12);
      `CHK("abort commits", 0, wr_cnt - w0)
      host_u.xfer({5'h03, 1'b1, 2'b00, 8'h00}, 12, rx);
      `CHK("abort oe", 1'b1, miso_oe_n)
      rd(5'h03, rx);
      `CHK("after abort", 8'ha5, rx)
      wr(5'h1f, 8'h5a, 16);
      rd(5'h1f, rx);
      `CHK("top index", 8'h5a, rx)
   endtask
   task automatic t_strobe();
      int n;
      n = 0;
      @(posedge clk) #1;
      result_ready = 1'b1;
      @(posedge clk) #1;
      result_ready = 1'b0;
      repeat (80) begin
         if (ready_clk_pin === 1'b0) n++;
         @(posedge clk) #1;
      end
      `CHK("strobe length", DRDY_CYCLES, n)
   endtask
   task automatic t_fwd();
      logic a;
      wr(SETUP_IDX, 8'h01, 16);
      `CHK("fwd sel", 1'b1, clock_forward_select)
      a = ready_clk_pin;
      @(posedge clk) #1;
      `CHK("fwd toggle", ~a, ready_clk_pin)
      wr(SETUP_IDX, 8'h00, 16);
      `CHK("fwd off", 1'b0, clock_forward_select)
      `CHK("strobe idle", 1'b1, ready_clk_pin)
   endtask
   initial begin
      repeat (16) @(posedge clk);
      #1;
      rstn = 1'b1;
      t_poll();
      t_wr_rd();
      t_abort();
      t_strobe();
      t_fwd();
      t_strobe();
      conclude();
   end
endmodule // iaspi_slave_tb_top
`default_nettype wire

/* iaspi_sync.sv */
// Two-stage pin synchronizer with edge detection for the serial pins
`timescale 1ns/1ns
`default_nettype none
module iaspi_sync (
   input wire logic clk,
   input wire logic rstn,
   input wire iaspi_pkg::iaspi_pins_t pins,
   output iaspi_pkg::iaspi_pins_t level,
   output var logic sclk_rise,
   output var logic sclk_fall,
   output var logic cs_fall,
   output var logic cs_rise
);
   import iaspi_pkg::*;
   iaspi_pins_t meta_q;
   iaspi_pins_t sync_q;
   iaspi_pins_t prev_q;

   // Idle pin levels: clock high, select high
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         meta_q <= '{sclk: 1'b1, cs_n: 1'b1, mosi: 1'b0};
         sync_q <= '{sclk: 1'b1, cs_n: 1'b1, mosi: 1'b0};
         prev_q <= '{sclk: 1'b1, cs_n: 1'b1, mosi: 1'b0};
      end else begin
         meta_q <= pins; // R17
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   assign level = sync_q;
   assign sclk_rise = sync_q.sclk & ~prev_q.sclk;
   assign sclk_fall = ~sync_q.sclk & prev_q.sclk;
   assign cs_fall = ~sync_q.cs_n & prev_q.cs_n;
   assign cs_rise = sync_q.cs_n & ~prev_q.cs_n;
endmodule // iaspi_sync
`default_nettype wire
